// ### logic/swt_watchdog.sv
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module swt_watchdog #(
  parameter bit RTC_VARIANT = 1'b0,
  parameter bit MAIN_INDEX = 1'b0,
  parameter bit BOOT_GROUP_ZERO = 1'b1,
  parameter int PRESCALE_W = 16,
  parameter int COUNT_W = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input wire logic rtcSlowClk,
  input wire logic flashBoot,
  // Reset requests and interrupts.
  output swt_pkg::swt_rst_type rstOut,
  output logic intLevel,
  output logic intEdge
);
  localparam bit BOOT_CAPABLE = RTC_VARIANT | BOOT_GROUP_ZERO;

  function automatic logic [6:0] lenCycles(input logic [2:0] code);
    int unsigned c;
    c = (swt_pkg::RST_LEN_NS[code] + swt_pkg::CLK_PERIOD_NS - 1) /
        swt_pkg::CLK_PERIOD_NS;
    return c[6:0];
  endfunction

  logic [31:0] cfg0_r;
  logic [31:0] cfg0_nxt;
  logic [PRESCALE_W-1:0] prescale_r;
  logic [COUNT_W-1:0] timeout_r [4];
  logic [31:0] wkey_r;
  logic [13:0] rtcCfg_r;
  logic intEna_r;
  logic intRaw_r;
  logic intEdge_r;
  logic [COUNT_W-1:0] cnt_r;
  logic [1:0] stage_r;
  logic [PRESCALE_W-1:0] preCnt_r;
  logic [1:0] slowSync_r;
  logic slowPrev_r;
  logic [1:0] bootSync_r;
  logic [1:0] strapCnt_r;
  logic [6:0] cpuCnt_r;
  logic [6:0] sysCnt_r;
  logic [1:0] cpuSel_r;
  logic rtcAlso_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] rdMux;

  // Bus decode.
  wire setup = psel & ~penable;
  wire wrAcc = psel & penable & pwrite;
  wire unlocked = wkey_r == swt_pkg::WKEY_RESET;
  wire wrOk = wrAcc & unlocked;
  wire wrCfg0 = wrOk & (paddr == swt_pkg::OFS_CONFIG0);
  wire wrPre = wrOk & (paddr == swt_pkg::OFS_PRESCALE);
  wire wrKey = wrAcc & (paddr == swt_pkg::OFS_WKEY);
  wire wrRtc = wrOk & (paddr == swt_pkg::OFS_RTC_CFG) & RTC_VARIANT;
  wire wrEna = wrOk & (paddr == swt_pkg::OFS_INT_ENA);
  wire wrClr = wrOk & (paddr == swt_pkg::OFS_INT_CLR);
  wire feedWr = wrOk & (paddr == swt_pkg::OFS_FEED);
  wire [11:0] stgOfs [4] = '{swt_pkg::OFS_STG0, swt_pkg::OFS_STG1,
                             swt_pkg::OFS_STG2, swt_pkg::OFS_STG3};

  // Configuration fields.
  wire wdtEn = cfg0_r[swt_pkg::CFG_EN_BIT];
  wire bootGuard = cfg0_r[swt_pkg::CFG_BOOT_BIT];
  wire edgeEn = cfg0_r[swt_pkg::CFG_EDGE_BIT];
  wire levelEn = cfg0_r[swt_pkg::CFG_LEVEL_BIT];
  wire [2:0] cpuLenCode = cfg0_r[swt_pkg::CFG_CPU_LEN_LSB +: 3];
  wire [2:0] sysLenCode = cfg0_r[swt_pkg::CFG_SYS_LEN_LSB +: 3];
  wire [6:0] cpuLenCyc = lenCycles(cpuLenCode);
  wire [6:0] sysLenCyc = lenCycles(sysLenCode);

  // Stage actions; only the RTC variant can name the combined reset.
  swt_pkg::swt_action_type stageAct [4];
  wire swt_pkg::swt_action_type bootAct = swt_pkg::swt_action_type'(
    RTC_VARIANT ? swt_pkg::ACT_SYSRTC : swt_pkg::ACT_SYS);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gStage
      wire [1:0] mainCode =
        cfg0_r[swt_pkg::CFG_STG0_LSB - swt_pkg::STG_FIELD_W * g +: 2];
      wire [2:0] rtcCode = rtcCfg_r[swt_pkg::RTC_ACT_W * g +: 3];
      wire [2:0] rawAct = RTC_VARIANT ? rtcCode : {1'b0, mainCode};
      wire [2:0] selAct = (g == 0 && bootGuard) ? bootAct : rawAct;
      assign stageAct[g] = swt_pkg::swt_action_type'(selAct);
      always_ff @(posedge clk) begin
        if (srst) begin
          timeout_r[g] <= COUNT_W'(swt_pkg::TIMEOUT_RESET);
        end else if (wrOk && paddr == stgOfs[g]) begin
          timeout_r[g] <= pwdata[COUNT_W-1:0];
        end
      end
    end
  endgenerate

  // Count tick: slow clock edge or prescaled bus clock.
  wire presTop = (prescale_r == '0) ||
                 (preCnt_r >= prescale_r - PRESCALE_W'(1));
  wire slowEdge = slowSync_r[1] & ~slowPrev_r;
  wire tick = RTC_VARIANT ? slowEdge : presTop;
  wire swt_pkg::swt_action_type curAct = stageAct[stage_r];
  wire fire = wdtEn & tick & (cnt_r == timeout_r[stage_r]);
  wire fireInt = fire & (curAct == swt_pkg::ACT_INT);
  wire fireCpu = fire & (curAct == swt_pkg::ACT_CPU);
  wire fireSys = fire & ((curAct == swt_pkg::ACT_SYS) |
                         (curAct == swt_pkg::ACT_SYSRTC));
  wire cpuActive = cpuCnt_r != '0;
  wire sysActive = sysCnt_r != '0;
  wire [1:0] cpuTarget = RTC_VARIANT ?
    rtcCfg_r[swt_pkg::RTC_CPUSEL_LSB +: 2] :
    (MAIN_INDEX ? 2'b10 : 2'b01);

  always_comb begin
    cfg0_nxt = cfg0_r;
    if (wrCfg0) begin
      cfg0_nxt = pwdata;
    end
    if (strapCnt_r == 2'd2 && bootSync_r[1] && BOOT_CAPABLE) begin
      cfg0_nxt[swt_pkg::CFG_EN_BIT] = 1'b1;
      cfg0_nxt[swt_pkg::CFG_BOOT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg0_r <= swt_pkg::CONFIG0_RESET;
      prescale_r <= PRESCALE_W'(swt_pkg::PRESCALE_RESET);
      wkey_r <= swt_pkg::WKEY_RESET;
      rtcCfg_r <= swt_pkg::RTC_CFG_RESET;
      intEna_r <= 1'b0;
    end else begin
      cfg0_r <= cfg0_nxt;
      if (wrPre) prescale_r <= pwdata[PRESCALE_W-1:0];
      if (wrKey) wkey_r <= pwdata;
      if (wrRtc) rtcCfg_r <= pwdata[13:0];
      if (wrEna) intEna_r <= pwdata[swt_pkg::INT_WDT_BIT];
    end
  end

  // Pin synchronisers and strap capture after reset release.
  always_ff @(posedge clk) begin
    if (srst) begin
      slowSync_r <= 2'b00;
      slowPrev_r <= 1'b0;
      bootSync_r <= 2'b00;
      strapCnt_r <= 2'd0;
    end else begin
      slowSync_r <= {slowSync_r[0], rtcSlowClk};
      slowPrev_r <= slowSync_r[1];
      bootSync_r <= {bootSync_r[0], flashBoot};
      if (strapCnt_r != 2'd3) strapCnt_r <= strapCnt_r + 2'd1;
    end
  end

  // Expiry counter and stage sequencer. Disabling parks it at stage 0.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      stage_r <= 2'd0;
      preCnt_r <= '0;
    end else begin
      preCnt_r <= presTop ? '0 : preCnt_r + PRESCALE_W'(1);
      if (feedWr || !wdtEn) begin
        cnt_r <= '0;
        stage_r <= 2'd0;
      end else if (fire) begin
        cnt_r <= '0;
        stage_r <= stage_r + 2'd1;
      end else if (tick) begin
        cnt_r <= cnt_r + COUNT_W'(1);
      end
    end
  end

  // Interrupt flag: an expiry in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      intRaw_r <= 1'b0;
      intEdge_r <= 1'b0;
    end else begin
      if (fireInt && levelEn) begin
        intRaw_r <= 1'b1;
      end else if (wrClr && pwdata[swt_pkg::INT_WDT_BIT]) begin
        intRaw_r <= 1'b0;
      end
      intEdge_r <= fireInt & edgeEn & intEna_r;
    end
  end

  // Reset pulse stretchers; a new request restarts the pulse.
  always_ff @(posedge clk) begin
    if (srst) begin
      cpuCnt_r <= '0;
      sysCnt_r <= '0;
      cpuSel_r <= 2'b00;
      rtcAlso_r <= 1'b0;
    end else begin
      if (fireCpu) begin
        cpuCnt_r <= cpuLenCyc;
        cpuSel_r <= cpuTarget;
      end else if (cpuActive) begin
        cpuCnt_r <= cpuCnt_r - 7'd1;
      end
      if (fireSys) begin
        sysCnt_r <= sysLenCyc;
        rtcAlso_r <= curAct == swt_pkg::ACT_SYSRTC;
      end else if (sysActive) begin
        sysCnt_r <= sysCnt_r - 7'd1;
      end
    end
  end

  assign rstOut = '{cpuPrimary: cpuActive & cpuSel_r[0],
                    cpuSecondary: cpuActive & cpuSel_r[1],
                    sys: sysActive,
                    rtc: sysActive & rtcAlso_r & RTC_VARIANT};
  assign intLevel = intRaw_r & intEna_r;
  assign intEdge = intEdge_r;

  // Read path, captured in the setup cycle so data comes from flops.
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      swt_pkg::OFS_CONFIG0: rdMux = cfg0_r;
      swt_pkg::OFS_PRESCALE: rdMux = 32'(prescale_r);
      swt_pkg::OFS_STG0: rdMux = 32'(timeout_r[0]);
      swt_pkg::OFS_STG1: rdMux = 32'(timeout_r[1]);
      swt_pkg::OFS_STG2: rdMux = 32'(timeout_r[2]);
      swt_pkg::OFS_STG3: rdMux = 32'(timeout_r[3]);
      swt_pkg::OFS_WKEY: rdMux = wkey_r;
      swt_pkg::OFS_RTC_CFG: rdMux = 32'(rtcCfg_r);
      swt_pkg::OFS_STATUS: rdMux = 32'(stage_r);
      swt_pkg::OFS_COUNT: rdMux = 32'(cnt_r);
      swt_pkg::OFS_INT_ENA: rdMux = 32'(intEna_r) << swt_pkg::INT_WDT_BIT;
      swt_pkg::OFS_INT_RAW: rdMux = 32'(intRaw_r) << swt_pkg::INT_WDT_BIT;
      swt_pkg::OFS_INT_ST: rdMux = 32'(intLevel) << swt_pkg::INT_WDT_BIT;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  wire hit = (paddr == swt_pkg::OFS_CONFIG0) ||
             (paddr == swt_pkg::OFS_PRESCALE) ||
             (paddr >= swt_pkg::OFS_STG0 && paddr <= swt_pkg::OFS_COUNT &&
              paddr[1:0] == 2'b00) ||
             (paddr >= swt_pkg::OFS_INT_ENA && paddr <= swt_pkg::OFS_INT_CLR
              && paddr[1:0] == 2'b00);

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr_r <= ~hit;
    end
  end

  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_feed;
    feedWr |=> (cnt_r == '0) && (stage_r == 2'd0);
  endproperty
  a_feed: assert property (p_feed) else $error("feed did not restart");

  property p_advance;
    fire && !feedWr |=> cnt_r == '0 && stage_r == $past(stage_r) + 2'd1;
  endproperty
  a_advance: assert property (p_advance) else $error("no advance");

  property p_wrap;
    fire && !feedWr && stage_r == 2'd3 |=> stage_r == 2'd0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stage did not wrap");

  property p_lock;
    wrAcc && !unlocked && paddr != swt_pkg::OFS_WKEY && strapCnt_r == 2'd3
      |=> $stable(cfg0_r) && $stable(prescale_r) && $stable(intEna_r);
  endproperty
  a_lock: assert property (p_lock) else $error("write passed lock");

  property p_key;
    @(posedge clk) disable iff (1'b0) srst |=> wkey_r == swt_pkg::WKEY_RESET;
  endproperty
  a_key: assert property (p_key) else $error("key reset wrong");

  property p_int;
    fireInt && levelEn |=> intRaw_r ##1 (intRaw_r || $past(wrClr));
  endproperty
  a_int: assert property (p_int) else $error("level int lost");

  property p_cpu;
    fireCpu |=> cpuActive [*3];
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu pulse short");

  property p_off;
    fire && curAct == swt_pkg::ACT_OFF
      |=> !intEdge && (cpuCnt_r == '0 || cpuCnt_r < $past(cpuCnt_r))
          && (sysCnt_r == '0 || sysCnt_r < $past(sysCnt_r));
  endproperty
  a_off: assert property (p_off) else $error("off stage acted");

  property p_nortc;
    fireSys |=> rstOut.rtc ==
      (RTC_VARIANT && $past(curAct) == swt_pkg::ACT_SYSRTC);
  endproperty
  a_nortc: assert property (p_nortc) else $error("main did rtc reset");

  property p_boot;
    bootGuard && stage_r == 2'd0 |-> curAct == bootAct;
  endproperty
  a_boot: assert property (p_boot) else $error("boot action wrong");

  c_feed: cover property (feedWr && stage_r != 2'd0);
  c_wrap: cover property (fire && stage_r == 2'd3);
  c_cpu: cover property (fireCpu);
  c_sys: cover property (fireSys);
endmodule
`default_nettype wire

// ### pkg/swt_pkg.sv
// Function
// - RTC variant counts on slow clock
// - Main variant uses 16-bit prescaler
// - Timeout match acts, clears counter, advances
// - Stages loop 0 to 3 then wrap
// - Per-stage action and timeout
// - Interrupt action raises an interrupt
// - Each main watchdog resets only its core
// - RTC variant resets selected cores
// - System reset spares the RTC domain
// - System plus RTC reset only in RTC variant
// - Disabled stage has no effect
// - Feed returns to stage 0, count 0
// - Key resets to magic; else protected
// - Protection blocks all writes except key
// - Flash boot auto-enables group zero, RTC
// - Boot guard forces stage 0 reset action
// - Main action codes off/int/cpu/system
// - Reset pulse length from 3-bit code
// - Main count period is prescale times base
// - Any unlocked write to feed register feeds
package swt_pkg;
  localparam logic [31:0] WKEY_RESET = 32'h50d83aa1;
  localparam logic [11:0] OFS_CONFIG0 = 12'h048;
  localparam logic [11:0] OFS_PRESCALE = 12'h04c;
  localparam logic [11:0] OFS_STG0 = 12'h050;
  localparam logic [11:0] OFS_STG1 = 12'h054;
  localparam logic [11:0] OFS_STG2 = 12'h058;
  localparam logic [11:0] OFS_STG3 = 12'h05c;
  localparam logic [11:0] OFS_FEED = 12'h060;
  localparam logic [11:0] OFS_WKEY = 12'h064;
  localparam logic [11:0] OFS_RTC_CFG = 12'h068;
  localparam logic [11:0] OFS_STATUS = 12'h06c;
  localparam logic [11:0] OFS_COUNT = 12'h070;
  localparam logic [11:0] OFS_INT_ENA = 12'h098;
  localparam logic [11:0] OFS_INT_RAW = 12'h09c;
  localparam logic [11:0] OFS_INT_ST = 12'h0a0;
  localparam logic [11:0] OFS_INT_CLR = 12'h0a4;
  localparam int CFG_EN_BIT = 31;
  localparam int CFG_STG0_LSB = 29;
  localparam int STG_FIELD_W = 2;
  localparam int CFG_EDGE_BIT = 22;
  localparam int CFG_LEVEL_BIT = 21;
  localparam int CFG_CPU_LEN_LSB = 18;
  localparam int CFG_SYS_LEN_LSB = 15;
  localparam int CFG_BOOT_BIT = 14;
  localparam int RTC_ACT_W = 3;
  localparam int RTC_CPUSEL_LSB = 12;
  localparam int INT_WDT_BIT = 2;
  localparam logic [31:0] CONFIG0_RESET = 32'h0000_0000;
  localparam logic [15:0] PRESCALE_RESET = 16'h0001;
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_ffff;
  localparam logic [13:0] RTC_CFG_RESET = 14'h0000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RST_LEN_NS [8] =
    '{100, 200, 300, 400, 500, 800, 1600, 3200};
  typedef enum logic [2:0] {
    ACT_OFF = 3'b000,
    ACT_INT = 3'b001,
    ACT_CPU = 3'b010,
    ACT_SYS = 3'b011,
    ACT_SYSRTC = 3'b100
  } swt_action_type;
  typedef struct packed {
    logic cpuPrimary;
    logic cpuSecondary;
    logic sys;
    logic rtc;
  } swt_rst_type;
endpackage

// ### bench/swt_reset_sink.sv
`timescale 1ns/10ps
`default_nettype none
module swt_reset_sink (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Reset requests from the watchdog.
  input wire swt_pkg::swt_rst_type rstIn,
  // Statistics, index 3 primary core down to 0 RTC domain.
  output logic [7:0] pulseCnt [4],
  output logic [7:0] lastLen [4]
);
  logic [7:0] runLen [4];
  logic [3:0] lines;
  assign lines = rstIn;
  // A pulse is only counted once it has ended, so its length is known.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (srst) begin
        pulseCnt[i] <= 8'h00;
        lastLen[i] <= 8'h00;
        runLen[i] <= 8'h00;
      end else if (lines[i]) begin
        runLen[i] <= runLen[i] + 8'h01;
      end else if (runLen[i] != 8'h00) begin
        lastLen[i] <= runLen[i];
        pulseCnt[i] <= pulseCnt[i] + 8'h01;
        runLen[i] <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/staged_watchdog_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module staged_watchdog_timer_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic flashBoot = 1'b0;
  logic pselRtc = 1'b0;
  logic rtcSlowClk = 1'b0;
  logic tgt = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, intLevel, intEdge;
  swt_pkg::swt_rst_type rstOut;
  logic [7:0] pulseCnt [4];
  logic [7:0] lastLen [4];
  logic [31:0] prdataRtc;
  logic preadyRtc;
  swt_pkg::swt_rst_type rstRtc;
  logic [7:0] pulseCntRtc [4];
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  // The slow clock runs far above nominal so that expiries stay short.
  always #160 rtcSlowClk = ~rtcSlowClk;
  swt_watchdog dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtcSlowClk(rtcSlowClk),
    .flashBoot(flashBoot), .rstOut(rstOut), .intLevel(intLevel),
    .intEdge(intEdge));
  swt_reset_sink sink (.clk(clk), .srst(srst), .rstIn(rstOut),
    .pulseCnt(pulseCnt), .lastLen(lastLen));
  swt_watchdog #(.RTC_VARIANT(1'b1)) dutRtc (.clk(clk), .srst(srst),
    .psel(pselRtc), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdataRtc), .pready(preadyRtc), .pslverr(),
    .rtcSlowClk(rtcSlowClk), .flashBoot(flashBoot), .rstOut(rstRtc),
    .intLevel(), .intEdge());
  swt_reset_sink sinkRtc (.clk(clk), .srst(srst), .rstIn(rstRtc),
    .pulseCnt(pulseCntRtc), .lastLen());
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= ~tgt;
    pselRtc <= tgt;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while ((tgt ? preadyRtc : pready) !== 1'b1 && n < 20);
    if ((tgt ? preadyRtc : pready) !== 1'b1) begin
      $display("[ERR] %0t pready %h exp %h", $time, pready, 1'b1);
      fail_count++;
      wrap_up();
    end
    rdat = tgt ? prdataRtc : prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pselRtc <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return rstOut.sys;
      1: return rstOut.cpuPrimary;
      3: return ~rstOut.sys;
      default: return intEdge;
    endcase
  endfunction
  task automatic wait_sig(input int k, input int lim);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (sig(k) !== 1'b1) begin
      $display("[ERR] %0t wait %h limit %h", $time, k, lim);
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic rst_dut(input logic fb);
    srst <= 1'b1;
    flashBoot <= fb;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic t_reset();
    rd(swt_pkg::OFS_WKEY);
    check(rdat, swt_pkg::WKEY_RESET);
    rd(swt_pkg::OFS_CONFIG0);
    check(rdat, swt_pkg::CONFIG0_RESET);
    rd(swt_pkg::OFS_PRESCALE);
    check(rdat, {16'h0000, swt_pkg::PRESCALE_RESET});
    rd(swt_pkg::OFS_STG0);
    check(rdat, swt_pkg::TIMEOUT_RESET);
    rd(12'h0f0);
    check({31'h0, rerr}, 32'h1);
    $display("reset values done");
  endtask
  task automatic t_protect();
    wr(swt_pkg::OFS_WKEY, 32'h0);
    wr(swt_pkg::OFS_PRESCALE, 32'h5);
    rd(swt_pkg::OFS_PRESCALE);
    check(rdat, 32'h1);
    rd(swt_pkg::OFS_WKEY);
    check(rdat, 32'h0);
    wr(swt_pkg::OFS_WKEY, swt_pkg::WKEY_RESET);
    wr(swt_pkg::OFS_PRESCALE, 32'h5);
    rd(swt_pkg::OFS_PRESCALE);
    check(rdat, 32'h5);
    wr(swt_pkg::OFS_PRESCALE, 32'h1);
    $display("protection done");
  endtask
  task automatic t_sysrst();
    logic [31:0] cfg;
    wr(swt_pkg::OFS_STG0, 32'h1);
    for (int c = 0; c < 8; c++) begin
      cfg = 32'hE000_0000 | (32'(c) << swt_pkg::CFG_SYS_LEN_LSB);
      wr(swt_pkg::OFS_CONFIG0, 32'h0);
      wr(swt_pkg::OFS_CONFIG0, cfg);
      wait_sig(0, 20);
      wait_sig(3, 100);
      @(posedge clk);
      check(32'(lastLen[1]), (swt_pkg::RST_LEN_NS[c] + 39) / 40);
    end
    wr(swt_pkg::OFS_CONFIG0, 32'h0);
    check(32'(pulseCnt[1]), 32'h8);
    check(32'(pulseCnt[0]), 32'h0);
    check(32'(pulseCnt[3]), 32'h0);
    $display("system reset lengths done");
  endtask
  task automatic t_stages();
    logic [7:0] s;
    s = pulseCnt[1];
    wr(swt_pkg::OFS_STG0, 32'h14);
    wr(swt_pkg::OFS_STG1, 32'h2);
    wr(swt_pkg::OFS_STG2, 32'h2);
    wr(swt_pkg::OFS_STG3, 32'h2);
    wr(swt_pkg::OFS_INT_ENA, 32'h4);
    // Stages int, cpu, off, sys; both interrupt kinds enabled.
    wr(swt_pkg::OFS_CONFIG0, 32'hB1E0_0000);
    wait_sig(2, 40);
    @(posedge clk);
    check({31'h0, intEdge}, 32'h0);
    check({31'h0, intLevel}, 32'h1);
    wait_sig(1, 40);
    check(32'(pulseCnt[1]), 32'(s));
    wait_sig(0, 40);
    rd(swt_pkg::OFS_STATUS);
    check(rdat, 32'h0);
    check(32'(pulseCnt[2]), 32'h0);
    check(32'(pulseCnt[3]), 32'h1);
    wr(swt_pkg::OFS_CONFIG0, 32'h0020_0000);
    repeat (5) @(posedge clk);
    check({31'h0, intLevel}, 32'h1);
    wr(swt_pkg::OFS_INT_ENA, 32'h0);
    @(posedge clk);
    check({31'h0, intLevel}, 32'h0);
    rd(swt_pkg::OFS_INT_RAW);
    check(rdat & 32'h4, 32'h4);
    wr(swt_pkg::OFS_INT_ENA, 32'h4);
    wr(swt_pkg::OFS_INT_CLR, 32'h4);
    @(posedge clk);
    check({31'h0, intLevel}, 32'h0);
    $display("stage loop and interrupt done");
  endtask
  task automatic t_feed();
    wr(swt_pkg::OFS_STG0, 32'h3e8);
    wr(swt_pkg::OFS_PRESCALE, 32'h4);
    wr(swt_pkg::OFS_CONFIG0, 32'h8000_0000);
    repeat (60) @(posedge clk);
    wr(swt_pkg::OFS_FEED, 32'ha5a5_0f0f);
    rd(swt_pkg::OFS_COUNT);
    check({31'h0, rdat < 32'h4}, 32'h1);
    repeat (40) @(posedge clk);
    rd(swt_pkg::OFS_COUNT);
    // A tick every fourth cycle puts the count near eleven here.
    check({31'h0, rdat >= 32'h9 && rdat <= 32'hd}, 32'h1);
    wr(swt_pkg::OFS_WKEY, 32'h0);
    wr(swt_pkg::OFS_FEED, 32'h0);
    rd(swt_pkg::OFS_COUNT);
    check({31'h0, rdat >= 32'hc}, 32'h1);
    wr(swt_pkg::OFS_WKEY, swt_pkg::WKEY_RESET);
    wr(swt_pkg::OFS_CONFIG0, 32'h0);
    wr(swt_pkg::OFS_PRESCALE, 32'h1);
    $display("feed done");
  endtask
  task automatic t_rtc();
    tgt = 1'b1;
    wr(swt_pkg::OFS_STG0, 32'h1);
    wr(swt_pkg::OFS_STG1, 32'h1);
    // Stage 0 resets system and RTC domain, stage 1 both cores.
    wr(swt_pkg::OFS_RTC_CFG, 32'h3014);
    wr(swt_pkg::OFS_CONFIG0, 32'h8000_0000);
    repeat (8) @(posedge clk);
    check(32'(pulseCntRtc[1]), 32'h0);
    repeat (72) @(posedge clk);
    check(32'(pulseCntRtc[0]), 32'h1);
    check(32'(pulseCntRtc[1]), 32'h1);
    check(32'(pulseCntRtc[2]), 32'h1);
    check(32'(pulseCntRtc[3]), 32'h1);
    wr(swt_pkg::OFS_CONFIG0, 32'h0);
    tgt = 1'b0;
    $display("rtc variant done");
  endtask
  task automatic t_boot();
    rst_dut(1'b1);
    repeat (6) @(posedge clk);
    rd(swt_pkg::OFS_CONFIG0);
    check(rdat & 32'h8000_4000, 32'h8000_4000);
    // The feed restarts the count below the shortened timeout.
    wr(swt_pkg::OFS_STG0, 32'h3);
    wr(swt_pkg::OFS_FEED, 32'h0);
    wait_sig(0, 30);
    wr(swt_pkg::OFS_CONFIG0, 32'h0);
    repeat (100) @(posedge clk);
    check(32'(pulseCnt[1]), 32'h1);
    rst_dut(1'b0);
    $display("boot guard done");
  endtask
  initial begin
    rst_dut(1'b0);
    t_reset();
    t_protect();
    t_sysrst();
    t_stages();
    t_feed();
    t_rtc();
    t_boot();
    wrap_up();
  end
endmodule
`default_nettype wire
